// ### acs_dev_end.sv
// Purpose: Converter end: decodes calibration, sync, standby, wake and reset commands.
// Assumes: CLK is the master clock; link logic runs on sclk.
// Notes: sclk with cs_n and din high clears the link logic (startup init).
// How it works
// - Offset calibration loads offset correction register.
// - Gain calibration loads gain correction register.
// - Data-ready high throughout calibration.
// - Data-ready low after calibration and settled result.
// - Host waits for data-ready low after calibration.
// - Host sends sync then wake.
// - Sync at master clock after wake's first sclk.
// - Standby command stops conversions.
// - Sclk with chip select low breaks standby.
// - Sclk while chip select high only clears the link logic, and only when din is high.
// - Wake command leaves standby, conversions resume.
// - Both wake byte values act identically.
// - Reset restores registers except clock-out rate bits.
// - Reset also ends continuous read.
// - Host sends reset after data-ready low in continuous read.
// - Host holds chip select low per command.
// - Wake decoded from 00h or FFh.
// - Sync decoded from FCh.
// - Register reset decoded from FEh.
module acs_dev_end (
   input wire logic CLK,
   input wire logic RESET_N,
   acs_link_if.dev LINK,
   input wire logic [23:0] ANALOG_CODE,
   input wire logic CTRL_WE,
   input wire logic [7:0] CTRL_WDATA,
   output logic [23:0] SAMPLE,
   output logic [23:0] OFFSET_CORR,
   output logic [23:0] GAIN_CORR,
   output logic [7:0] CONV_CTRL,
   output logic CONT_READ,
   output logic IN_STANDBY
);
   // ----------------------------------------------------------------------
   // Link side, clocked by sclk
   // ----------------------------------------------------------------------
   logic [2:0] bit_cnt_r, bit_cnt_nxt; // Bit position within the byte.
   logic [6:0] shift_r, shift_nxt; // Bits received so far.
   logic [7:0] byte_r, byte_nxt; // Last complete command byte.
   logic byte_tgl_r, byte_tgl_nxt; // Flips once per complete byte.
   logic act_tgl_r, act_tgl_nxt; // Flips on the first sclk of each byte.

   // Next values of the link shifter.
   always_comb
   begin
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt = shift_r;
      byte_nxt = byte_r;
      byte_tgl_nxt = byte_tgl_r;
      act_tgl_nxt = act_tgl_r;
      if (LINK.cs_n)
      begin
         // Deselected: only the init pattern (din high) clears state.
         if (LINK.din)
         begin
            bit_cnt_nxt = 3'h0;
            shift_nxt = 7'h00;
            byte_nxt = 8'h00;
            byte_tgl_nxt = 1'b0;
            act_tgl_nxt = 1'b0;
         end
      end
      else
      begin
         // First edge of a byte signals activity to the master clock side.
         if (bit_cnt_r == 3'h0)
         begin
            act_tgl_nxt = ~act_tgl_r;
         end
         shift_nxt = {shift_r[5:0], LINK.din};
         bit_cnt_nxt = bit_cnt_r + 3'h1;
         if (bit_cnt_r == 3'h7)
         begin
            byte_nxt = {shift_r, LINK.din};
            byte_tgl_nxt = ~byte_tgl_r;
         end
      end
   end

   // Register the link shifter.
   always_ff @(posedge LINK.sclk)
   begin
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      byte_r <= byte_nxt;
      byte_tgl_r <= byte_tgl_nxt;
      act_tgl_r <= act_tgl_nxt;
   end

   // ----------------------------------------------------------------------
   // Crossing into the master clock domain
   // ----------------------------------------------------------------------
   logic bt_s1_r, bt_s2_r, bt_s3_r; // Byte toggle synchroniser and history.
   logic at_s1_r, at_s2_r, at_s3_r; // Activity toggle synchroniser and history.
   logic [6:0] guard_r, guard_nxt; // Startup guard counter.
   logic guard_done; // Events are trusted only after the guard.
   logic byte_evt; // One cycle per received byte.
   logic act_evt; // One cycle per first sclk of a byte.

   // Guard counter; toggles are undefined until the host init has run.
   always_comb
   begin
      guard_done = (guard_r == 7'(acs_pkg::GUARD_CYCLES));
      guard_nxt = guard_done ? guard_r : guard_r + 7'h01;
   end

   always_ff @(posedge CLK)
   begin
      bt_s1_r <= byte_tgl_r;
      bt_s2_r <= bt_s1_r;
      bt_s3_r <= bt_s2_r;
      at_s1_r <= act_tgl_r;
      at_s2_r <= at_s1_r;
      at_s3_r <= at_s2_r;
      if (!RESET_N)
      begin
         guard_r <= 7'h00;
      end
      else
      begin
         guard_r <= guard_nxt;
      end
   end

   // Edge detection on the second and third stages only.
   assign byte_evt = guard_done & (bt_s2_r ^ bt_s3_r);
   assign act_evt = guard_done & (at_s2_r ^ at_s3_r);

   // ----------------------------------------------------------------------
   // Conversion, calibration and mode control
   // ----------------------------------------------------------------------
   acs_pkg::acs_dev_state_t state_r, state_nxt; // Operating state.
   logic [11:0] cnt_r, cnt_nxt; // Conversion or calibration cycle count.
   logic data_ready_n_n_r, data_ready_n_n_nxt; // Data-ready, active low.
   logic gain_cal_r, gain_cal_nxt; // Running calibration is the gain one.
   logic [23:0] ofs_r, ofs_nxt; // Offset correction register.
   logic [23:0] gain_r, gain_nxt; // Gain correction register.
   logic [7:0] ctrl_r, ctrl_nxt; // Converter control register.
   logic cont_r, cont_nxt; // Continuous-read mode.
   logic stby_r, stby_nxt; // Standby indicator.
   logic [23:0] sample_r, sample_nxt; // Last corrected conversion result.
   logic conv_done; // Conversion counter at its last cycle.

   // Next state of the converter control.
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      data_ready_n_n_nxt = data_ready_n_n_r;
      gain_cal_nxt = gain_cal_r;
      ofs_nxt = ofs_r;
      gain_nxt = gain_r;
      ctrl_nxt = CTRL_WE ? CTRL_WDATA : ctrl_r;
      cont_nxt = cont_r;
      stby_nxt = stby_r;
      sample_nxt = sample_r;
      conv_done = (cnt_r == 12'(acs_pkg::CONV_CYCLES - 1));
      unique case (state_r)
         acs_pkg::ST_RUN:
         begin
            // Free-running conversions; result published at the end.
            cnt_nxt = conv_done ? 12'h000 : cnt_r + 12'h001;
            if (conv_done)
            begin
               sample_nxt = ANALOG_CODE - ofs_r;
               data_ready_n_n_nxt = 1'b0;
            end
            else if (cnt_r == 12'(acs_pkg::CONV_CYCLES - 1 - acs_pkg::DATA_READY_N_HIGH_CYCLES))
            begin
               data_ready_n_n_nxt = 1'b1;
            end
         end
         acs_pkg::ST_CAL:
         begin
            // Calibration: data-ready stays high, then one settling conversion.
            data_ready_n_n_nxt = 1'b1;
            cnt_nxt = cnt_r + 12'h001;
            if (cnt_r == 12'(acs_pkg::CAL_CYCLES - 1))
            begin
               if (gain_cal_r)
               begin
                  gain_nxt = ANALOG_CODE;
               end
               else
               begin
                  ofs_nxt = ANALOG_CODE;
               end
               cnt_nxt = 12'h000;
               state_nxt = acs_pkg::ST_RUN;
            end
         end
         acs_pkg::ST_SYNC_WAIT:
         begin
            // Held until the first sclk of the next byte restarts conversion.
            if (act_evt)
            begin
               cnt_nxt = 12'h000;
               data_ready_n_n_nxt = 1'b1;
               state_nxt = acs_pkg::ST_RUN;
            end
         end
         acs_pkg::ST_STANDBY:
         begin
            // Conversions stopped; sclk with chip select low or wake resumes.
            data_ready_n_n_nxt = 1'b1;
            if (act_evt || (byte_evt && (byte_r == acs_pkg::CMD_WAKE_ZERO ||
                                         byte_r == acs_pkg::CMD_WAKE_ONE)))
            begin
               cnt_nxt = 12'h000;
               stby_nxt = 1'b0;
               state_nxt = acs_pkg::ST_RUN;
            end
         end
         default:
         begin
            state_nxt = acs_pkg::ST_RUN;
         end
      endcase
      // Command decode, skipped entirely while calibrating or in standby.
      if (byte_evt && state_r != acs_pkg::ST_CAL && state_r != acs_pkg::ST_STANDBY)
      begin
         unique case (byte_r)
            acs_pkg::CMD_SYS_OFS_CAL, acs_pkg::CMD_SYS_GAIN_CAL:
            begin
               gain_cal_nxt = (byte_r == acs_pkg::CMD_SYS_GAIN_CAL);
               cnt_nxt = 12'h000;
               data_ready_n_n_nxt = 1'b1;
               state_nxt = acs_pkg::ST_CAL;
            end
            acs_pkg::CMD_SYNC:
            begin
               state_nxt = acs_pkg::ST_SYNC_WAIT;
            end
            acs_pkg::CMD_STANDBY:
            begin
               data_ready_n_n_nxt = 1'b1;
               stby_nxt = 1'b1;
               state_nxt = acs_pkg::ST_STANDBY;
            end
            acs_pkg::CMD_REG_RESET:
            begin
               ctrl_nxt = (acs_pkg::CTRL_DEFAULT & ~acs_pkg::CTRL_RATE_MASK) |
                          (ctrl_r & acs_pkg::CTRL_RATE_MASK);
               ofs_nxt = acs_pkg::OFS_DEFAULT;
               gain_nxt = acs_pkg::GAIN_DEFAULT;
               cont_nxt = 1'b0;
            end
            acs_pkg::CMD_CONT_READ:
            begin
               cont_nxt = 1'b1;
            end
            acs_pkg::CMD_STOP_CONT:
            begin
               cont_nxt = 1'b0;
            end
            default:
            begin
               // Wake (00h or FFh) while running is a no-op, as are others.
               cont_nxt = cont_r;
            end
         endcase
      end
   end

   // Register the converter control.
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         state_r <= acs_pkg::ST_RUN;
         cnt_r <= 12'h000;
         data_ready_n_n_r <= 1'b1;
         gain_cal_r <= 1'b0;
         ofs_r <= acs_pkg::OFS_DEFAULT;
         gain_r <= acs_pkg::GAIN_DEFAULT;
         ctrl_r <= acs_pkg::CTRL_DEFAULT;
         cont_r <= 1'b0;
         stby_r <= 1'b0;
         sample_r <= 24'h000000;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         data_ready_n_n_r <= data_ready_n_n_nxt;
         gain_cal_r <= gain_cal_nxt;
         ofs_r <= ofs_nxt;
         gain_r <= gain_nxt;
         ctrl_r <= ctrl_nxt;
         cont_r <= cont_nxt;
         stby_r <= stby_nxt;
         sample_r <= sample_nxt;
      end
   end

   // Outputs straight from registers.
   assign LINK.data_ready_n = data_ready_n_n_r;
   assign SAMPLE = sample_r;
   assign OFFSET_CORR = ofs_r;
   assign GAIN_CORR = gain_r;
   assign CONV_CTRL = ctrl_r;
   assign CONT_READ = cont_r;
   assign IN_STANDBY = stby_r;
endmodule : acs_dev_end

// ### acs_host_end.sv
// Purpose: Host end: shifts single command bytes out on the serial link.
// Assumes: sclk is CLK divided by 2*SCLK_HALF_CYCLES, idle low.
// Notes: After reset it gives the link four sclk pulses with chip select and din high.
module acs_host_end (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_BYTE,
   output logic CMD_READY,
   acs_link_if.host LINK
);
   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   acs_pkg::acs_host_state_t state_r, state_nxt; // Host sequencer state.
   logic [6:0] cnt_r, cnt_nxt; // Init and gap counter.
   logic [3:0] div_r, div_nxt; // Serial clock divider.
   logic [2:0] bit_r, bit_nxt; // Bit being shifted.
   logic [7:0] sh_r, sh_nxt; // Command byte in flight.
   logic sclk_r, sclk_nxt; // Serial clock out.
   logic cs_n_r, cs_n_nxt; // Chip select out.
   logic din_r, din_nxt; // Data out.
   logic cont_r, cont_nxt; // Device is in continuous read.
   logic go_r, go_nxt; // Shift pending after a data-ready wait.
   logic ready_r, ready_nxt; // Command accept strobe enable.
   logic dr_s1_r, dr_s2_r; // Data-ready synchroniser.
   logic half_done; // Divider at half period.
   logic is_cal; // Byte in flight starts a calibration.

   // Next values of the sequencer.
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      div_nxt = div_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      sclk_nxt = sclk_r;
      cs_n_nxt = cs_n_r;
      din_nxt = din_r;
      cont_nxt = cont_r;
      go_nxt = go_r;
      half_done = (div_r == 4'(acs_pkg::SCLK_HALF_CYCLES - 1));
      is_cal = (sh_r == acs_pkg::CMD_SYS_OFS_CAL) || (sh_r == acs_pkg::CMD_SYS_GAIN_CAL);
      unique case (state_r)
         acs_pkg::H_INIT:
         begin
            // Clock with chip select and din high to clear the device shifter.
            div_nxt = half_done ? 4'h0 : div_r + 4'h1;
            cnt_nxt = cnt_r + 7'h01;
            if (half_done && cnt_r < 7'(acs_pkg::INIT_PULSE_CYCLES))
            begin
               sclk_nxt = ~sclk_r;
            end
            if (cnt_r == 7'(acs_pkg::GUARD_CYCLES))
            begin
               sclk_nxt = 1'b0;
               din_nxt = 1'b0;
               state_nxt = acs_pkg::H_IDLE;
            end
         end
         acs_pkg::H_IDLE:
         begin
            // Take a byte; reset in continuous read waits for data-ready low.
            if (CMD_VALID && ready_r)
            begin
               sh_nxt = CMD_BYTE;
               div_nxt = 4'h0;
               bit_nxt = 3'h0;
               if (cont_r && CMD_BYTE == acs_pkg::CMD_REG_RESET)
               begin
                  go_nxt = 1'b1;
                  state_nxt = acs_pkg::H_WAIT_LO;
               end
               else
               begin
                  cs_n_nxt = 1'b0;
                  din_nxt = CMD_BYTE[7];
                  state_nxt = acs_pkg::H_SHIFT;
               end
            end
         end
         acs_pkg::H_SHIFT:
         begin
            // Chip select low for the whole byte, MSB first, rising sampled.
            div_nxt = half_done ? 4'h0 : div_r + 4'h1;
            if (half_done)
            begin
               sclk_nxt = ~sclk_r;
               if (sclk_r)
               begin
                  bit_nxt = bit_r + 3'h1;
                  if (bit_r == 3'h7)
                  begin
                     cs_n_nxt = 1'b1;
                     cnt_nxt = 7'h00;
                     state_nxt = acs_pkg::H_GAP;
                  end
                  else
                  begin
                     // The byte stays whole so the calibration wait can still decode it.
                     din_nxt = sh_r[3'h6 - bit_r];
                  end
               end
            end
         end
         acs_pkg::H_GAP:
         begin
            // Deselected gap; sclk stays idle, so standby is not disturbed.
            din_nxt = 1'b0;
            cnt_nxt = cnt_r + 7'h01;
            if (cnt_r == 7'(2 * acs_pkg::SCLK_HALF_CYCLES))
            begin
               state_nxt = is_cal ? acs_pkg::H_WAIT_HI : acs_pkg::H_IDLE;
            end
         end
         acs_pkg::H_WAIT_HI:
         begin
            // Calibration started once data-ready goes high.
            if (dr_s2_r)
            begin
               state_nxt = acs_pkg::H_WAIT_LO;
            end
         end
         acs_pkg::H_WAIT_LO:
         begin
            // Data-ready low: calibration done, or reset may now be sent.
            if (!dr_s2_r)
            begin
               go_nxt = 1'b0;
               if (go_r)
               begin
                  cs_n_nxt = 1'b0;
                  din_nxt = sh_r[7];
                  state_nxt = acs_pkg::H_SHIFT;
               end
               else
               begin
                  state_nxt = acs_pkg::H_IDLE;
               end
            end
         end
         default:
         begin
            state_nxt = acs_pkg::H_IDLE;
         end
      endcase
      // Track continuous-read mode from the bytes sent.
      if (state_r == acs_pkg::H_IDLE && CMD_VALID && ready_r)
      begin
         if (CMD_BYTE == acs_pkg::CMD_CONT_READ)
         begin
            cont_nxt = 1'b1;
         end
         else if (CMD_BYTE == acs_pkg::CMD_STOP_CONT || CMD_BYTE == acs_pkg::CMD_REG_RESET)
         begin
            cont_nxt = 1'b0;
         end
      end
      // Accept again only once idle, never in the cycle of a take.
      ready_nxt = (state_nxt == acs_pkg::H_IDLE) && !(CMD_VALID && ready_r);
   end

   // Register the sequencer; data-ready passes two flip-flops first.
   always_ff @(posedge CLK)
   begin
      dr_s1_r <= LINK.data_ready_n;
      dr_s2_r <= dr_s1_r;
      if (!RESET_N)
      begin
         state_r <= acs_pkg::H_INIT;
         cnt_r <= 7'h00;
         div_r <= 4'h0;
         bit_r <= 3'h0;
         sh_r <= 8'h00;
         sclk_r <= 1'b0;
         cs_n_r <= 1'b1;
         din_r <= 1'b1;
         cont_r <= 1'b0;
         go_r <= 1'b0;
         ready_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         div_r <= div_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         sclk_r <= sclk_nxt;
         cs_n_r <= cs_n_nxt;
         din_r <= din_nxt;
         cont_r <= cont_nxt;
         go_r <= go_nxt;
         ready_r <= ready_nxt;
      end
   end

   // Outputs straight from registers.
   assign LINK.sclk = sclk_r;
   assign LINK.cs_n = cs_n_r;
   assign LINK.din = din_r;
   assign CMD_READY = ready_r;
endmodule : acs_host_end

// ### acs_link_assertions.sv
// Purpose: Wire checks of the command link.
// Assumes: CLK samples all; RESET_N synchronous, active low.
// Notes: Bytes are rebuilt from din to spot calibration and standby.
module acs_link_assertions (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic data_ready_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sclk_r, sclk_nxt; // Last sclk level.
   logic [7:0] sh_r, sh_nxt; // Bits so far, MSB first.
   logic [3:0] n_r, n_nxt; // Bits in this frame.
   logic [11:0] cal_r, cal_nxt; // Cycles since a calibration byte.
   logic rise, last, is_cal; // Frame rise; eighth rise; calibration byte.
   // Rebuilds bytes and times calibrations.
   always_comb
   begin
      rise = sclk && !sclk_r && !cs_n;
      last = rise && n_r == 4'h7;
      sclk_nxt = sclk;
      sh_nxt = rise ? {sh_r[6:0], din} : sh_r;
      is_cal = sh_nxt inside {acs_pkg::CMD_SYS_OFS_CAL, acs_pkg::CMD_SYS_GAIN_CAL};
      n_nxt = cs_n ? 4'h0 : n_r + {3'h0, rise};
      cal_nxt = (cal_r > 12'h008 && !data_ready_n) ? 12'h000 : cal_r + {11'h0, cal_r != 12'h000};
      if (last && is_cal)
         cal_nxt = 12'h001;
   end
   // Registers the rebuild state.
   always_ff @(posedge CLK)
   begin
      sclk_r <= RESET_N && sclk_nxt;
      sh_r <= RESET_N ? sh_nxt : 8'h00;
      n_r <= RESET_N ? n_nxt : 4'h0;
      cal_r <= RESET_N ? cal_nxt : 12'h000;
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);
   sequence s_cal;
      last && is_cal;
   endsequence
   sequence s_stby;
      last && sh_nxt == acs_pkg::CMD_STANDBY;
   endsequence
   AST_CAL_RISE: assert property (s_cal |-> ##[1:8] data_ready_n)
      else $error("no data-ready rise at calibration");
   AST_CAL_HOLD: assert property (cal_r > 12'h008 && cal_r < 12'h9C4 |-> data_ready_n)
      else $error("data-ready low in calibration");
   AST_CAL_END: assert property (cal_r < 12'hC1C)
      else $error("calibration never ended");
   AST_CAL_QUIET: assert property (cal_r > 12'h008 |-> !$fell(cs_n))
      else $error("command during calibration");
   AST_STBY_HIGH: assert property (s_stby |-> ##[1:8] data_ready_n [*8])
      else $error("data-ready not high in standby");
   AST_FRAME_LEN: assert property ($fell(cs_n) |-> !cs_n [*8])
      else $error("short chip-select frame");
   AST_FRAME_BITS: assert property ($rose(cs_n) |-> n_r == 4'h8)
      else $error("frame not one whole byte");
   AST_DIN_SETUP: assert property (!cs_n && !$past(cs_n) && $changed(din) |-> !sclk)
      else $error("din moved with sclk high");
endmodule : acs_link_assertions

// ### acs_link_if.sv
// Purpose: Serial command link between host and converter.
// Assumes: The host makes sclk; cs_n and din change on host-side sclk phases.
// Notes: No two-way pins; read-back data is not carried.
interface acs_link_if;
   logic sclk; // Serial clock, made by the host.
   logic cs_n; // Chip select, active low.
   logic din; // Command data, sampled on rising sclk.
   logic data_ready_n; // Data-ready, active low, from the converter.
   modport dev (input sclk, input cs_n, input din, output data_ready_n);
   modport host (output sclk, output cs_n, output din, input data_ready_n);
endinterface : acs_link_if

// ### acs_pkg.sv
// Purpose: Shared constants and types for the calibration/sync/standby command link.
// Assumes: CLK is the 125 MHz master clock on both ends.
// Notes: Times are in ns; cycle counts derive from them.
package acs_pkg;
   // ----------------------------------------------------------------------
   // Command byte codes
   // ----------------------------------------------------------------------
   localparam logic [7:0] CMD_WAKE_ZERO = 8'h00; // Wake, all zeros form.
   localparam logic [7:0] CMD_WAKE_ONE = 8'hFF; // Wake, all ones form.
   localparam logic [7:0] CMD_SYNC = 8'hFC; // Synchronize conversions.
   localparam logic [7:0] CMD_STANDBY = 8'hFD; // Enter standby.
   localparam logic [7:0] CMD_REG_RESET = 8'hFE; // Registers to defaults.
   localparam logic [7:0] CMD_SYS_OFS_CAL = 8'hF3; // System offset calibration.
   localparam logic [7:0] CMD_SYS_GAIN_CAL = 8'hF4; // System gain calibration.
   localparam logic [7:0] CMD_CONT_READ = 8'h03; // Enter continuous read.
   localparam logic [7:0] CMD_STOP_CONT = 8'h0F; // Leave continuous read.
   // ----------------------------------------------------------------------
   // Register defaults and fields
   // ----------------------------------------------------------------------
   localparam logic [7:0] CTRL_DEFAULT = 8'h20; // Converter control default.
   localparam logic [7:0] CTRL_RATE_MASK = 8'h60; // Clock-out rate bits 6:5.
   localparam logic [23:0] OFS_DEFAULT = 24'h000000; // Offset correction default.
   localparam logic [23:0] GAIN_DEFAULT = 24'h400000; // Gain correction default.
   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8; // Master clock period.
   localparam int CONV_PERIOD_NS = 4000; // One conversion.
   localparam int CAL_PERIOD_NS = 20000; // One system calibration.
   localparam int DATA_READY_N_HIGH_NS = 400; // Data-ready high before an update.
   localparam int CONV_CYCLES = (CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAL_CYCLES = (CAL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DATA_READY_N_HIGH_CYCLES = (DATA_READY_N_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCLK_HALF_CYCLES = 5; // Host divider: serial clock period 80 ns.
   localparam int GUARD_CYCLES = 64; // Startup window for link initialisation.
   localparam int INIT_PULSE_CYCLES = 40; // Host init clocking inside the window.
   // ----------------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_CAL = 3'b001,
      ST_SYNC_WAIT = 3'b010,
      ST_STANDBY = 3'b011
   } acs_dev_state_t;
   typedef enum logic [2:0] {
      H_INIT = 3'b000,
      H_IDLE = 3'b001,
      H_SHIFT = 3'b010,
      H_GAP = 3'b011,
      H_WAIT_HI = 3'b100,
      H_WAIT_LO = 3'b101
   } acs_host_state_t;
endpackage : acs_pkg

// ### test_adc_cal_sync_standby_cmds.sv
// Purpose: Runs both link ends through calibration, reset, standby and sync.
// Assumes: One 125 MHz clock; the host end makes the serial clock.
// Notes: Expected values come from package defaults and the analog codes driven.
module test_adc_cal_sync_standby_cmds;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] KEEP = acs_pkg::CTRL_RATE_MASK; // Bits a reset keeps.
   logic clk = 1'b0, reset_n = 1'b0, ctrl_we = 1'b0, cmd_valid = 1'b0, cmd_ready, cont, stby;
   logic [7:0] ctrl_wdata = 8'h00, cmd_byte = 8'h00, ctrl, e8;
   logic [7:0] olds [2] = '{8'hFF, 8'h9F}; // Control values before a reset.
   logic [7:0] wakes [2] = '{acs_pkg::CMD_WAKE_ZERO, acs_pkg::CMD_WAKE_ONE}; // Wake forms.
   logic [23:0] analog = 24'h123456, sample, ofs, gain;
   int fail_count = 0, checked = 0, cnt = 0;
   acs_link_if link ();
   acs_dev_end i_acs_dev_end (.CLK(clk), .RESET_N(reset_n), .LINK(link), .ANALOG_CODE(analog),
      .CTRL_WE(ctrl_we), .CTRL_WDATA(ctrl_wdata), .SAMPLE(sample), .OFFSET_CORR(ofs),
      .GAIN_CORR(gain), .CONV_CTRL(ctrl), .CONT_READ(cont), .IN_STANDBY(stby));
   acs_host_end i_acs_host_end (.CLK(clk), .RESET_N(reset_n), .CMD_VALID(cmd_valid),
      .CMD_BYTE(cmd_byte), .CMD_READY(cmd_ready), .LINK(link));
   acs_link_assertions i_acs_link_assertions (.CLK(clk), .RESET_N(reset_n), .sclk(link.sclk),
      .cs_n(link.cs_n), .din(link.din), .data_ready_n(link.data_ready_n));
   // Master clock.
   initial forever #4 clk = ~clk;
   task automatic check(input string nm, input logic [23:0] s, input logic [23:0] e);
      checked++;
      if (s !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic wait_ready();
      int n = 0;
      do @(negedge clk); while (cmd_ready !== 1'b1 && n++ < 9000);
      // A host end that never comes back is a failure of the run.
      if (cmd_ready !== 1'b1)
      begin
         fail_count++;
         results();
      end
   endtask : wait_ready
   // Hands one byte over and waits until the host end is idle again.
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_byte <= b;
      wait_ready();
      @(posedge clk);
      cmd_valid <= 1'b0;
      repeat (3) @(posedge clk);
      wait_ready();
   endtask : send
   task automatic results();
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results
   // Main sequence.
   initial
   begin
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      send(acs_pkg::CMD_SYS_OFS_CAL);
      check("offset", ofs, 24'h123456);
      check("sample", sample, 24'h000000);
      @(posedge clk);
      analog <= 24'h2ABCDE;
      send(acs_pkg::CMD_SYS_GAIN_CAL);
      check("gain", gain, 24'h2ABCDE);
      check("sample", sample, 24'h188888);
      check("ready", {23'h0, link.data_ready_n}, 24'h0);
      foreach (olds[i])
      begin
         @(posedge clk);
         ctrl_we <= 1'b1;
         ctrl_wdata <= olds[i];
         @(posedge clk);
         ctrl_we <= 1'b0;
         send(acs_pkg::CMD_CONT_READ);
         check("cont", {23'h0, cont}, 24'h1);
         send(acs_pkg::CMD_REG_RESET);
         e8 = (olds[i] & KEEP) | (acs_pkg::CTRL_DEFAULT & ~KEEP);
         check("cont", {23'h0, cont}, 24'h0);
         check("ctrl", {16'h0, ctrl}, {16'h0, e8});
         check("gain", gain, acs_pkg::GAIN_DEFAULT);
         check("offset", ofs, acs_pkg::OFS_DEFAULT);
      end
      foreach (wakes[i])
      begin
         send(acs_pkg::CMD_STANDBY);
         repeat (1000) @(negedge clk);
         check("standby", {23'h0, stby}, 24'h1);
         check("ready", {23'h0, link.data_ready_n}, 24'h1);
         send(wakes[i]);
         repeat (500) @(negedge clk);
         check("standby", {23'h0, stby}, 24'h0);
         check("ready", {23'h0, link.data_ready_n}, 24'h0);
      end
      send(acs_pkg::CMD_SYNC);
      send(acs_pkg::CMD_WAKE_ZERO);
      do @(negedge clk); while (link.data_ready_n !== 1'b1 && ++cnt < 2000);
      do @(negedge clk); while (link.data_ready_n !== 1'b0 && ++cnt < 2000);
      check("sync", {23'h0, cnt > 350 && cnt < 460}, 24'h1);
      results();
   end
   // Watchdog against a hang.
   initial
   begin
      repeat (40000) @(posedge clk);
      fail_count++;
      results();
   end
endmodule : test_adc_cal_sync_standby_cmds
